// [verilog/cti_pkg.sv]
package cti_pkg;
	localparam logic [6:0] TARGET_ADDR = 7'h6b;
	localparam int CLK_HZ = 10_000_000;
	localparam int KEEPALIVE_S = 175;
	localparam logic [7:0] MAKER_CODE = 8'h5a; // arbitrary value
	localparam logic [7:0] PART_CODE = 8'h3c; // arbitrary value
	localparam logic [7:0] ADDR_OPT0_L = 8'h00;
	localparam logic [7:0] ADDR_OPT0_H = 8'h01;
	localparam logic [7:0] ADDR_ICHG_L = 8'h02;
	localparam logic [7:0] ADDR_ICHG_H = 8'h03;
	localparam logic [7:0] ADDR_VCHG_L = 8'h04;
	localparam logic [7:0] ADDR_VCHG_H = 8'h05;
	localparam logic [7:0] ADDR_VREV_L = 8'h06;
	localparam logic [7:0] ADDR_VREV_H = 8'h07;
	localparam logic [7:0] ADDR_VIN_L = 8'h0a;
	localparam logic [7:0] ADDR_VIN_H = 8'h0b;
	localparam logic [7:0] ADDR_IIN_L = 8'h24;
	localparam logic [7:0] ADDR_IIN_H = 8'h25;
	localparam logic [7:0] ADDR_MAKER = 8'h2e;
	localparam logic [7:0] ADDR_PART = 8'h2f;
	localparam logic [7:0] ADDR_OPT1_L = 8'h30;
	localparam logic [7:0] ADDR_OPT1_H = 8'h31;
	// option0 low byte fields
	localparam int BIT_HOLD_OFF = 0;
	localparam int BIT_PTM = 1;
	localparam int POS_KA_SEL = 2;
	localparam logic [1:0] KA_SEL_RST = 2'h3;
	// charge current 256 mA at 128 mA/lsb -> bit field value
	localparam logic [15:0] ICHG_KEEPALIVE = 16'h0100;
	localparam logic [15:0] ICHG_RST = 16'h0000;
	localparam logic [15:0] MV_PER_CELL = 16'h1068; // 4200 mV
	localparam logic [2:0] CELLS_RST = 3'h1;
	localparam int FILT_LEN = 3;
	// host side link clock divider: 10 MHz / (2*13) ~ 385 kHz
	localparam int SCL_HALF = 13;
	localparam logic [5:0] APB_CTRL = 6'h00;
	localparam logic [5:0] APB_WDATA = 6'h04;
	localparam logic [5:0] APB_STAT = 6'h08;
	localparam logic [5:0] APB_RDATA = 6'h0c;
	function automatic logic [15:0] vchg_default(input logic [2:0] cells);
		vchg_default = 16'(MV_PER_CELL * cells);
	endfunction : vchg_default
endpackage : cti_pkg

// [verilog/cti_bus_if.sv]
interface cti_bus_if;
	logic scl_o_dev;
	logic scl_oe_dev;
	logic sda_o_dev;
	logic sda_oe_dev;
	logic scl_o_host;
	logic scl_oe_host;
	logic sda_o_host;
	logic sda_oe_host;
	logic scl;
	logic sda;
	// open drain wired-and, released lines pull high
	assign scl = ~((scl_oe_dev & ~scl_o_dev) | (scl_oe_host & ~scl_o_host));
	assign sda = ~((sda_oe_dev & ~sda_o_dev) | (sda_oe_host & ~sda_o_host));
	modport dev (input scl, input sda, output scl_o_dev, output scl_oe_dev,
		output sda_o_dev, output sda_oe_dev);
	modport host (input scl, input sda, output scl_o_host,
		output scl_oe_host, output sda_o_host, output sda_oe_host);
endinterface : cti_bus_if

// [verilog/cti_target.sv]
// Summary of operation
// [R01] answer only address 6Bh, D6h/D7h
// [R02] fixed maker code and part code registers
// [R03] works with bus clock up to 400 kHz
// [R04] data changes only while clock low
// [R05] detect START and STOP
// [R06] bus busy from START until STOP
// [R07] eight bits MSB first plus acknowledge
// [R08] may stretch clock low between bytes
// [R09] receiver pulls data low on ninth pulse
// [R10] high on ninth pulse is not-acknowledge
// [R11] first byte: address then direction bit
// [R12] undefined register address gets NACK, idle
// [R13] single and multi byte reads and writes
// [R14] host writes low byte then high byte
// [R15] low byte pending until high byte arrives
// [R16] high byte without low byte is ignored
// [R17] pair discarded if gap exceeds keep-alive timeout
// [R18] default voltage is 4.2V times cell count
// [R19] host ends charge: hold-off or zero current
// [R20] keep-alive expiry sets current to 256 mA
// [R21] pass-through drives high sides on, low off
// [R22] keep-alive restarts on voltage/current writes
// [R23] register pointer advances after each byte
// [R24] synchronise and filter lines before detection
//
// Implementation choices: the APB interface to the registers and the register offsets.
module cti_target
	import cti_pkg::*;
#(
	parameter int KA_CYCLES = CLK_HZ * KEEPALIVE_S
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	cti_bus_if.dev bus,
	input wire logic [2:0] cell_count_strap,
	output logic charge_hold_off_bit,
	output logic passthrough_enable,
	output logic [1:0] keepalive_timeout_select,
	output logic [15:0] charge_current_setting,
	output logic [15:0] charge_voltage_setting,
	output logic [15:0] reverse_output_voltage,
	output logic [15:0] input_voltage_floor,
	output logic [15:0] active_input_current_limit,
	output logic high_side_on,
	output logic low_side_on,
	output logic bus_busy
);
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000, ST_ADDR = 3'b001, ST_ACK = 3'b011,
		ST_RX = 3'b010, ST_TX = 3'b110, ST_TXACK = 3'b111
	} cti_state_t;

	logic [1:0] scl_sync_reg, sda_sync_reg;
	logic [FILT_LEN-1:0] scl_hist_reg, sda_hist_reg;
	logic scl_f_reg, sda_f_reg, scl_prev_reg, sda_prev_reg;
	cti_state_t state_reg;
	logic [7:0] shift_reg, ptr_reg, pend_reg;
	logic [3:0] bitcnt_reg;
	logic first_reg, rd_reg, ack_ok_reg, pend_valid_reg;
	logic ptr_ack_reg;
	logic [7:0] pend_addr_reg;
	logic [7:0] opt0_h_reg, opt1_l_reg, opt1_h_reg;
	logic [31:0] ka_cnt_reg;
	logic sda_drv_reg;
	logic strap_done_reg, vchg_written_reg;
	logic scl_rise, scl_fall, start_det, stop_det, byte_done;
	logic wr_ev;
	logic [7:0] rdata;

	function automatic logic known(input logic [7:0] a);
		case (a)
		ADDR_OPT0_L, ADDR_OPT0_H, ADDR_ICHG_L, ADDR_ICHG_H, ADDR_VCHG_L,
		ADDR_VCHG_H, ADDR_VREV_L, ADDR_VREV_H, ADDR_VIN_L, ADDR_VIN_H,
		ADDR_IIN_L, ADDR_IIN_H, ADDR_MAKER, ADDR_PART, ADDR_OPT1_L,
		ADDR_OPT1_H: known = 1'b1;
		default: known = 1'b0;
		endcase
	endfunction : known

	function automatic logic is_pair_low(input logic [7:0] a);
		is_pair_low = (a == ADDR_ICHG_L) || (a == ADDR_VCHG_L) ||
			(a == ADDR_VREV_L) || (a == ADDR_VIN_L) || (a == ADDR_IIN_L);
	endfunction : is_pair_low

	// two stage sync then majority-free filter: all samples must agree
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			scl_sync_reg <= 2'b11;
			sda_sync_reg <= 2'b11;
			scl_hist_reg <= '1;
			sda_hist_reg <= '1;
			scl_f_reg <= 1'b1;
			sda_f_reg <= 1'b1;
			scl_prev_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
		end else begin
			scl_sync_reg <= {scl_sync_reg[0], bus.scl}; // [R24]
			sda_sync_reg <= {sda_sync_reg[0], bus.sda}; // [R24]
			scl_hist_reg <= {scl_hist_reg[FILT_LEN-2:0], scl_sync_reg[1]};
			sda_hist_reg <= {sda_hist_reg[FILT_LEN-2:0], sda_sync_reg[1]};
			if (&scl_hist_reg)
				scl_f_reg <= 1'b1;
			else if (~|scl_hist_reg)
				scl_f_reg <= 1'b0;
			if (&sda_hist_reg)
				sda_f_reg <= 1'b1;
			else if (~|sda_hist_reg)
				sda_f_reg <= 1'b0;
			scl_prev_reg <= scl_f_reg;
			sda_prev_reg <= sda_f_reg;
		end
	end

	assign scl_rise = scl_f_reg & ~scl_prev_reg;
	assign scl_fall = ~scl_f_reg & scl_prev_reg;
	assign start_det = scl_f_reg & scl_prev_reg & sda_prev_reg & ~sda_f_reg; // [R05]
	assign stop_det = scl_f_reg & scl_prev_reg & ~sda_prev_reg & sda_f_reg; // [R05]
	assign byte_done = scl_rise && bitcnt_reg == 4'd7;
	assign wr_ev = (state_reg == ST_ACK) && scl_fall && ack_ok_reg &&
		!first_reg && !ptr_ack_reg && !rd_reg && bitcnt_reg == 4'd9;

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst)
			bus_busy <= 1'b0;
		else if (start_det)
			bus_busy <= 1'b1; // [R06]
		else if (stop_det)
			bus_busy <= 1'b0; // [R06]
	end

	always_comb begin
		case (ptr_reg)
		ADDR_OPT0_L: rdata = {3'b000, keepalive_timeout_select,
			1'b0, passthrough_enable, charge_hold_off_bit};
		ADDR_OPT0_H: rdata = opt0_h_reg;
		ADDR_ICHG_L: rdata = charge_current_setting[7:0];
		ADDR_ICHG_H: rdata = charge_current_setting[15:8];
		ADDR_VCHG_L: rdata = charge_voltage_setting[7:0];
		ADDR_VCHG_H: rdata = charge_voltage_setting[15:8];
		ADDR_VREV_L: rdata = reverse_output_voltage[7:0];
		ADDR_VREV_H: rdata = reverse_output_voltage[15:8];
		ADDR_VIN_L: rdata = input_voltage_floor[7:0];
		ADDR_VIN_H: rdata = input_voltage_floor[15:8];
		ADDR_IIN_L: rdata = active_input_current_limit[7:0];
		ADDR_IIN_H: rdata = active_input_current_limit[15:8];
		ADDR_MAKER: rdata = MAKER_CODE; // [R02]
		ADDR_PART: rdata = PART_CODE; // [R02]
		ADDR_OPT1_L: rdata = opt1_l_reg;
		ADDR_OPT1_H: rdata = opt1_h_reg;
		default: rdata = 8'h00;
		endcase
	end

	// serial engine; bitcnt 0..7 data bits, ack phase follows
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_reg <= ST_IDLE;
			shift_reg <= 8'h00;
			bitcnt_reg <= 4'd0;
			first_reg <= 1'b0;
			rd_reg <= 1'b0;
			ack_ok_reg <= 1'b0;
			ptr_reg <= 8'h00;
			sda_drv_reg <= 1'b0;
			ptr_ack_reg <= 1'b0;
		end else if (start_det) begin
			state_reg <= ST_ADDR;
			bitcnt_reg <= 4'd0;
			sda_drv_reg <= 1'b0;
		end else if (stop_det) begin
			state_reg <= ST_IDLE;
			sda_drv_reg <= 1'b0;
		end else begin
			case (state_reg)
			ST_IDLE: sda_drv_reg <= 1'b0;
			ST_ADDR, ST_RX: begin
				if (scl_rise) begin
					shift_reg <= {shift_reg[6:0], sda_f_reg}; // [R07]
					bitcnt_reg <= bitcnt_reg + 4'd1;
				end
				if (scl_fall && bitcnt_reg == 4'd8) begin
					bitcnt_reg <= 4'd9;
					state_reg <= ST_ACK;
					if (state_reg == ST_ADDR) begin
						first_reg <= 1'b1;
						ptr_ack_reg <= 1'b0;
						rd_reg <= shift_reg[0]; // [R11]
						ack_ok_reg <= shift_reg[7:1] == TARGET_ADDR; // [R01]
						sda_drv_reg <= shift_reg[7:1] == TARGET_ADDR; // [R09]
					end else if (first_reg) begin
						ack_ok_reg <= known(shift_reg); // [R12]
						sda_drv_reg <= known(shift_reg); // [R12]
						ptr_reg <= shift_reg;
						first_reg <= 1'b0;
						ptr_ack_reg <= 1'b1;
					end else begin
						ptr_ack_reg <= 1'b0;
						ack_ok_reg <= 1'b1;
						sda_drv_reg <= 1'b1; // [R09]
					end
				end
			end
			ST_ACK: if (scl_fall) begin
				bitcnt_reg <= 4'd0;
				if (!ack_ok_reg) begin
					state_reg <= ST_IDLE; // [R10] [R12]
					sda_drv_reg <= 1'b0;
				end else if (rd_reg && first_reg && shift_reg[0] &&
					shift_reg[7:1] == TARGET_ADDR) begin
					state_reg <= ST_TX;
					first_reg <= 1'b0;
					sda_drv_reg <= ~rdata[7]; // [R04]
					shift_reg <= {rdata[6:0], 1'b0};
					ptr_reg <= ptr_reg + 8'd1; // [R23]
				end else begin
					state_reg <= ST_RX;
					sda_drv_reg <= 1'b0;
					// address and pointer bytes leave the pointer alone
					if (!first_reg && !ptr_ack_reg)
						ptr_reg <= ptr_reg + 8'd1; // [R23]
				end
			end
			ST_TX: begin
				if (scl_rise)
					bitcnt_reg <= bitcnt_reg + 4'd1;
				if (scl_fall) begin
					if (bitcnt_reg == 4'd8) begin
						state_reg <= ST_TXACK;
						sda_drv_reg <= 1'b0; // [R09]
					end else begin
						sda_drv_reg <= ~shift_reg[7]; // [R04] [R07]
						shift_reg <= {shift_reg[6:0], 1'b0};
					end
				end
			end
			ST_TXACK: if (scl_rise) begin
				if (sda_f_reg)
					state_reg <= ST_IDLE; // [R10]
				else begin
					state_reg <= ST_TX; // [R13]
					bitcnt_reg <= 4'd0;
					shift_reg <= rdata;
					ptr_reg <= ptr_reg + 8'd1; // [R23]
				end
			end
			default: state_reg <= ST_IDLE;
			endcase
			if (state_reg == ST_TXACK && scl_fall)
				sda_drv_reg <= ~shift_reg[7];
		end
	end

	// first data byte clears the register-address phase
	assign bus.sda_o_dev = 1'b0;
	assign bus.sda_oe_dev = sda_drv_reg;
	assign bus.scl_o_dev = 1'b0;
	assign bus.scl_oe_dev = 1'b0; // [R08] logic always ready, never stretches

	// register writes on the falling edge ending an acknowledged data byte
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			charge_hold_off_bit <= 1'b0;
			passthrough_enable <= 1'b0;
			keepalive_timeout_select <= KA_SEL_RST;
			charge_current_setting <= ICHG_RST;
			charge_voltage_setting <= 16'h0000;
			reverse_output_voltage <= 16'h0000;
			input_voltage_floor <= 16'h0000;
			active_input_current_limit <= 16'h0000;
			opt0_h_reg <= 8'h00;
			opt1_l_reg <= 8'h00;
			opt1_h_reg <= 8'h00;
			pend_reg <= 8'h00;
			pend_addr_reg <= 8'h00;
			pend_valid_reg <= 1'b0;
			ka_cnt_reg <= 32'd0;
			strap_done_reg <= 1'b0;
			vchg_written_reg <= 1'b0;
		end else begin
			if (!vchg_written_reg)
				charge_voltage_setting <= vchg_default(cell_count_strap); // [R18]
			strap_done_reg <= 1'b1;
			if (keepalive_timeout_select != 2'b00 && pend_valid_reg ||
				keepalive_timeout_select != 2'b00)
				ka_cnt_reg <= ka_cnt_reg + 32'd1;
			if (keepalive_timeout_select != 2'b00 &&
				ka_cnt_reg >= 32'(KA_CYCLES)) begin
				charge_current_setting <= ICHG_KEEPALIVE; // [R20]
				pend_valid_reg <= 1'b0; // [R17]
				ka_cnt_reg <= 32'd0;
			end
			if (wr_ev) begin
				if (is_pair_low(ptr_reg)) begin
					pend_reg <= shift_reg; // [R15]
					pend_addr_reg <= ptr_reg;
					pend_valid_reg <= 1'b1;
				end else begin
					pend_valid_reg <= 1'b0; // [R14]
					if (pend_valid_reg && pend_addr_reg + 8'd1 == ptr_reg) begin
						case (pend_addr_reg) // [R15] [R16]
						ADDR_ICHG_L: charge_current_setting <= {shift_reg, pend_reg};
						ADDR_VCHG_L: begin
							charge_voltage_setting <= {shift_reg, pend_reg};
							vchg_written_reg <= 1'b1;
						end
						ADDR_VREV_L: reverse_output_voltage <= {shift_reg, pend_reg};
						ADDR_VIN_L: input_voltage_floor <= {shift_reg, pend_reg};
						ADDR_IIN_L:
							active_input_current_limit <= {shift_reg, pend_reg};
						default: ;
						endcase
						if (pend_addr_reg == ADDR_ICHG_L || pend_addr_reg == ADDR_VCHG_L)
							ka_cnt_reg <= 32'd0; // [R22]
					end
					case (ptr_reg)
					ADDR_OPT0_L: begin
						charge_hold_off_bit <= shift_reg[BIT_HOLD_OFF]; // [R19]
						passthrough_enable <= shift_reg[BIT_PTM]; // [R21]
						keepalive_timeout_select <= shift_reg[POS_KA_SEL +: 2];
						ka_cnt_reg <= 32'd0; // [R22]
					end
					ADDR_OPT0_H: opt0_h_reg <= shift_reg;
					ADDR_OPT1_L: opt1_l_reg <= shift_reg;
					ADDR_OPT1_H: opt1_h_reg <= shift_reg;
					default: ;
					endcase
				end
			end
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			high_side_on <= 1'b0;
			low_side_on <= 1'b0;
		end else begin
			high_side_on <= passthrough_enable; // [R21]
			low_side_on <= ~passthrough_enable; // [R21]
		end
	end
endmodule : cti_target

// [verilog/cti_host.sv]
module cti_host
	import cti_pkg::*;
(
	input wire logic sys_clk,
	input wire logic sys_rst,
	cti_bus_if.host bus,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [5:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);
	// ctrl: [0] ignored (any write while not busy starts), [1] read, [2] stop at end, [3] start first
	typedef enum logic [2:0] {
		H_IDLE = 3'b000, H_START = 3'b001, H_BIT = 3'b011,
		H_ACK = 3'b010, H_STOP = 3'b110
	} cti_hstate_t;

	cti_hstate_t st_reg;
	logic [1:0] scl_sync_reg, sda_sync_reg;
	logic [7:0] tx_reg, rx_reg;
	logic [7:0] div_reg;
	logic [3:0] bit_reg;
	logic [1:0] ph_reg;
	logic rd_reg, stop_reg, nack_reg, busy_reg, scl_drv_reg, sda_drv_reg;
	logic tick;

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			scl_sync_reg <= 2'b11;
			sda_sync_reg <= 2'b11;
		end else begin
			scl_sync_reg <= {scl_sync_reg[0], bus.scl}; // [R24]
			sda_sync_reg <= {sda_sync_reg[0], bus.sda};
		end
	end

	// divider pauses while target stretches the clock
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst)
			div_reg <= 8'd0;
		else if (div_reg == 8'(SCL_HALF - 1) || st_reg == H_IDLE)
			div_reg <= 8'd0;
		else if (!(ph_reg == 2'd1 && !scl_sync_reg[1])) // [R08]
			div_reg <= div_reg + 8'd1; // [R03]
	end
	assign tick = div_reg == 8'(SCL_HALF - 1);

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_reg <= H_IDLE;
			tx_reg <= 8'h00;
			rx_reg <= 8'h00;
			bit_reg <= 4'd0;
			ph_reg <= 2'd0;
			rd_reg <= 1'b0;
			stop_reg <= 1'b0;
			nack_reg <= 1'b0;
			busy_reg <= 1'b0;
			scl_drv_reg <= 1'b0;
			sda_drv_reg <= 1'b0;
			pready <= 1'b0;
			prdata <= 32'd0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && penable && !pready;
			if (psel && penable && !pready) begin
				if (pwrite && paddr == APB_CTRL && !busy_reg) begin
					busy_reg <= 1'b1;
					rd_reg <= pwdata[1];
					stop_reg <= pwdata[2];
					st_reg <= pwdata[3] ? H_START : H_BIT;
					ph_reg <= 2'd0;
					bit_reg <= 4'd0;
				end else if (pwrite && paddr == APB_WDATA)
					tx_reg <= pwdata[7:0];
				prdata <= paddr == APB_STAT ? {30'd0, nack_reg, busy_reg} :
					paddr == APB_RDATA ? {24'd0, rx_reg} : 32'd0;
			end
			case (st_reg)
			H_IDLE: ;
			H_START: if (tick) begin // [R05]
				ph_reg <= ph_reg + 2'd1;
				if (ph_reg == 2'd0) begin
					sda_drv_reg <= 1'b0;
					scl_drv_reg <= 1'b0;
				end else if (ph_reg == 2'd1)
					sda_drv_reg <= 1'b1;
				else begin
					scl_drv_reg <= 1'b1;
					ph_reg <= 2'd0;
					st_reg <= H_BIT;
				end
			end
			H_BIT, H_ACK: if (tick) begin
				ph_reg <= ph_reg == 2'd1 ? 2'd0 : 2'd1;
				if (ph_reg == 2'd0) begin
					scl_drv_reg <= 1'b0; // [R04]
				end else begin
					scl_drv_reg <= 1'b1;
					if (st_reg == H_BIT) begin
						rx_reg <= {rx_reg[6:0], sda_sync_reg[1]}; // [R07]
						bit_reg <= bit_reg + 4'd1;
						if (bit_reg == 4'd7)
							st_reg <= H_ACK;
					end else begin
						if (!rd_reg)
							nack_reg <= sda_sync_reg[1]; // [R10]
						st_reg <= stop_reg ? H_STOP : H_IDLE;
						busy_reg <= stop_reg;
						ph_reg <= 2'd0;
					end
				end
				if (ph_reg == 2'd1 && st_reg == H_BIT && bit_reg == 4'd7)
					sda_drv_reg <= rd_reg && !stop_reg; // [R09]
				else if (ph_reg == 2'd1 && st_reg == H_BIT)
					sda_drv_reg <= !rd_reg && !tx_reg[3'd6 - bit_reg[2:0]];
				else if (ph_reg == 2'd1)
					sda_drv_reg <= stop_reg;
			end
			H_STOP: if (tick) begin
				ph_reg <= ph_reg + 2'd1;
				if (ph_reg == 2'd0)
					scl_drv_reg <= 1'b0;
				else if (ph_reg == 2'd1) begin
					sda_drv_reg <= 1'b0; // [R05]
					st_reg <= H_IDLE;
					busy_reg <= 1'b0;
				end
			end
			default: st_reg <= H_IDLE;
			endcase
			if (st_reg != H_START && st_reg != H_IDLE && bit_reg == 4'd0 &&
				ph_reg == 2'd0 && st_reg == H_BIT && div_reg == 8'd0)
				sda_drv_reg <= !rd_reg && !tx_reg[7]; // [R11]
		end
	end

	assign bus.scl_o_host = 1'b0;
	assign bus.scl_oe_host = scl_drv_reg;
	assign bus.sda_o_host = 1'b0;
	assign bus.sda_oe_host = sda_drv_reg;
endmodule : cti_host

// [tb/cti_monitor.sv]
module cti_monitor (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic scl,
	input wire logic sda,
	input wire logic scl_o_dev,
	input wire logic scl_oe_dev,
	input wire logic sda_o_dev,
	input wire logic sda_oe_dev,
	input wire logic bus_busy
);
	timeunit 1ns;
	timeprecision 1ns;
	logic scl_q, sda_q, wr_q;
	logic [1:0] idx;
	logic [3:0] cnt;
	logic [7:0] sh;
	wire pull = sda_oe_dev & ~sda_o_dev;
	wire rise = scl & ~scl_q;
	wire start = scl & scl_q & sda_q & ~sda;
	wire stop = scl & scl_q & ~sda_q & sda;
	wire ninth = rise && cnt == 4'h8;
	wire reg_ok = sh inside {[8'h00:8'h07], 8'h0a, 8'h0b, 8'h24, 8'h25,
		[8'h2e:8'h31]};
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl;
			sda_q <= sda;
		end
	end
	// bit and byte position on the wire
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt <= 4'h0;
			idx <= 2'h0;
			wr_q <= 1'b0;
		end else if (start) begin
			cnt <= 4'h0;
			idx <= 2'h0;
		end else if (rise) begin
			cnt <= ninth ? 4'h0 : cnt + 4'h1;
			if (ninth && idx != 2'h3) begin
				idx <= idx + 2'h1;
			end
			if (ninth && idx == 2'h0) begin
				wr_q <= sh == 8'hd6;
			end
		end
	end
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			sh <= 8'h00;
		end else if (rise && cnt != 4'h8) begin
			sh <= {sh[6:0], sda};
		end
	end
	property p_no_stretch;
		scl_oe_dev |-> scl_o_dev;
	endproperty
	a_no_stretch: assert property (p_no_stretch)
		else $error("target pulled the clock line");
	property p_dev_sda_low;
		pull != $past(pull) |-> !scl;
	endproperty
	a_dev_sda_low: assert property (p_dev_sda_low)
		else $error("target moved data while clock high");
	property p_busy_on;
		start |-> ##[1:10] bus_busy;
	endproperty
	a_busy_on: assert property (p_busy_on)
		else $error("busy missing after start");
	property p_busy_off;
		stop |-> ##[1:10] !bus_busy;
	endproperty
	a_busy_off: assert property (p_busy_off)
		else $error("busy stuck after stop");
	property p_ack_addr;
		ninth && idx == 2'h0 && sh[7:1] == 7'h6b |-> pull[*8];
	endproperty
	a_ack_addr: assert property (p_ack_addr)
		else $error("own address not acknowledged");
	property p_ignore;
		ninth && idx == 2'h0 && sh[7:1] != 7'h6b |-> !pull;
	endproperty
	a_ignore: assert property (p_ignore)
		else $error("foreign address acknowledged");
	property p_bad_reg;
		ninth && idx == 2'h1 && wr_q |-> pull == reg_ok;
	endproperty
	a_bad_reg: assert property (p_bad_reg)
		else $error("register pointer acknowledge wrong");
	property p_release;
		ninth && idx != 2'h0 && !wr_q |-> !pull;
	endproperty
	a_release: assert property (p_release)
		else $error("target held data on read acknowledge");
	property p_scl_high;
		$rose(scl) |-> scl[*8] ##1 scl[*4];
	endproperty
	a_scl_high: assert property (p_scl_high)
		else $error("clock high phase too short");
endmodule : cti_monitor

// [tb/cti_target_tb.sv]
module cti_target_tb;
	import cti_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int KA = 2000;
	logic sys_clk, sys_rst, psel, penable, pwrite, pready, pslverr, nk;
	logic [5:0] paddr;
	logic [31:0] pwdata, prdata, st;
	logic [2:0] cells;
	logic hold_off, pt_en, hs_on, ls_on, busy;
	logic [1:0] ka_sel;
	logic [15:0] ichg, vchg, vrev, vin, iin, q;
	int num_errors = 0;
	int n_tests = 0;
	int cyc = 0;
	cti_bus_if bus ();
	cti_target #(.KA_CYCLES(KA)) u_cti_target (.sys_clk(sys_clk),
		.sys_rst(sys_rst), .bus(bus), .cell_count_strap(cells),
		.charge_hold_off_bit(hold_off), .passthrough_enable(pt_en),
		.keepalive_timeout_select(ka_sel), .charge_current_setting(ichg),
		.charge_voltage_setting(vchg), .reverse_output_voltage(vrev),
		.input_voltage_floor(vin), .active_input_current_limit(iin),
		.high_side_on(hs_on), .low_side_on(ls_on), .bus_busy(busy));
	cti_host u_cti_host (.sys_clk(sys_clk), .sys_rst(sys_rst), .bus(bus),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));
	cti_monitor u_cti_monitor (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.scl(bus.scl), .sda(bus.sda), .scl_o_dev(bus.scl_o_dev),
		.scl_oe_dev(bus.scl_oe_dev), .sda_o_dev(bus.sda_o_dev),
		.sda_oe_dev(bus.sda_oe_dev), .bus_busy(busy));
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	task automatic results;
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : results
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 60000) begin
			num_errors++;
			results();
		end
	end
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		n_tests++;
		if (g !== e) begin
			num_errors++;
			$display("FAIL t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [5:0] a,
		input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		st = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// one byte on the link; f: 8 start, 4 stop, 2 read
	task automatic xb(input logic [7:0] d, input logic [3:0] f);
		apb(1'b1, APB_WDATA, {24'h0, d});
		apb(1'b1, APB_CTRL, {28'h0, f | 4'h1});
		do apb(1'b0, APB_STAT, 32'h0); while (st[0] !== 1'b0);
		nk = st[1];
		apb(1'b0, APB_RDATA, 32'h0);
	endtask : xb
	task automatic wr(input logic [7:0] r, input logic [15:0] d, input int n);
		xb(8'hd6, 4'h8);
		xb(r, 4'h0);
		xb(d[7:0], n == 1 ? 4'h4 : 4'h0);
		if (n == 2) begin
			xb(d[15:8], 4'h4);
		end
	endtask : wr
	task automatic rd(input logic [7:0] r);
		xb(8'hd6, 4'h8);
		xb(r, 4'h0);
		xb(8'hd7, 4'h8);
		xb(8'h00, 4'h2);
		q[7:0] = st[7:0];
		xb(8'h00, 4'h6);
		q[15:8] = st[7:0];
	endtask : rd
	initial begin
		sys_rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 6'h00;
		pwdata = 32'h0000_0000;
		cells = 3'h3;
		repeat (6) @(posedge sys_clk);
		sys_rst <= 1'b0;
		repeat (2) @(posedge sys_clk);
		chk(vchg, 16'h3138);
		chk({ichg[15:2], ka_sel}, 16'h0003);
		chk({15'h0, pslverr}, 16'h0000);
		cells <= 3'h2;
		repeat (10) @(posedge sys_clk);
		chk(vchg, 16'h20d0);
		$display("test defaults done");
		rd(ADDR_MAKER);
		chk(q, {PART_CODE, MAKER_CODE});
		xb(8'ha0, 4'hc);
		chk({15'h0, nk}, 16'h0001);
		xb(8'hd6, 4'h8);
		xb(8'h10, 4'h4);
		chk({15'h0, nk}, 16'h0001);
		$display("test identity and refusal done");
		wr(ADDR_OPT0_L, 16'h0000, 1);
		wr(ADDR_ICHG_L, 16'h0000, 2);
		chk(ichg, 16'h0000);
		wr(ADDR_ICHG_L, 16'h0005, 1);
		chk({ichg[15:1], nk}, 16'h0000);
		wr(ADDR_ICHG_H, 16'h0000, 1);
		chk(ichg, 16'h0005);
		wr(ADDR_VREV_H, 16'h0012, 1);
		chk(vrev, 16'h0000);
		wr(ADDR_VCHG_L, 16'h1234, 2);
		chk(vchg, 16'h1234);
		wr(ADDR_VREV_L, 16'h0bb8, 2);
		chk(vrev, 16'h0bb8);
		wr(ADDR_VIN_L, 16'h00a5, 2);
		chk(vin, 16'h00a5);
		wr(ADDR_IIN_L, 16'h0123, 2);
		chk(iin, 16'h0123);
		rd(ADDR_VCHG_L);
		chk(q, 16'h1234);
		$display("test pairs done");
		wr(ADDR_OPT0_L, 16'h000e, 1);
		chk({13'h0, pt_en, hs_on, ls_on}, 16'h0006);
		wr(ADDR_OPT0_L, 16'h000d, 1);
		chk({13'h0, hold_off, pt_en, hs_on}, 16'h0004);
		$display("test options done");
		wr(ADDR_ICHG_L, 16'h0a05, 2);
		repeat (600) @(posedge sys_clk);
		wr(ADDR_VCHG_L, 16'h1068, 2);
		chk(ichg, 16'h0a05);
		repeat (1200) @(posedge sys_clk);
		chk(ichg, 16'h0a05);
		repeat (KA + 200) @(posedge sys_clk);
		chk(ichg, ICHG_KEEPALIVE);
		wr(ADDR_ICHG_L, 16'h0007, 1);
		repeat (KA + 200) @(posedge sys_clk);
		wr(ADDR_ICHG_H, 16'h0000, 1);
		chk(ichg, ICHG_KEEPALIVE);
		wr(ADDR_OPT0_L, 16'h0001, 1);
		wr(ADDR_ICHG_L, 16'h0000, 2);
		repeat (KA + 200) @(posedge sys_clk);
		chk({ichg[15:2], ka_sel}, 16'h0000);
		$display("test keep-alive done");
		results();
	end
endmodule : cti_target_tb
